// ---- design/ocdc_top.sv ----
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ocdc_top #(
    parameter logic [7:0] XPT_DEFAULT = ocdc_pkg::XPT_RST,
    parameter logic [ocdc_pkg::SKEW_W-1:0] SKEW_DEFAULT = ocdc_pkg::SKEW_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic out_disable_pin,
    output ocdc_pkg::ocdc_pin_s [ocdc_pkg::NUM_DRV-1:0] pin_p,
    output ocdc_pkg::ocdc_pin_s [ocdc_pkg::NUM_DRV-1:0] pin_n,
    output logic [ocdc_pkg::NUM_DRV-1:0][1:0] drive_sel,
    output logic [ocdc_pkg::NUM_DRV-1:0] power_down
);
    import ocdc_pkg::*;

    logic [7:0] xpt;
    logic [11:0] dis_cfg;
    ocdc_fmt_s [NUM_DRV-1:0] fmt;
    logic [NUM_DIV-1:0][HALF_W-1:0] half;
    logic [NUM_DIV-1:0][SKEW_W-1:0] skew;
    logic hard_req;
    logic align_req;
    logic [NUM_DIV-1:0] dclk;
    logic [NUM_DIV-1:0] drise;
    logic [NUM_DRV-1:0] active;

    // Bus decode.
    wire setup = psel & ~penable & ~pready;
    wire wr_go = psel & penable & pready & pwrite;
    wire [3:0] page = paddr[7:4];
    wire [1:0] idx = paddr[3:2];
    wire hit_ctrl = paddr == ADDR_CTRL;
    wire hit_xpt = paddr == ADDR_XPT;
    wire hit_dis = paddr == ADDR_DIS;
    wire hit_fmt = paddr == ADDR_FMT;
    wire hit_stat = paddr == ADDR_STAT;
    wire hit_half = (page == PAGE_HALF) & (paddr[1:0] == 2'b00);
    wire hit_skew = (page == PAGE_SKEW) & (paddr[1:0] == 2'b00);
    wire mapped = hit_ctrl | hit_xpt | hit_dis | hit_fmt | hit_stat | hit_half | hit_skew;
    wire [31:0] lane = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] wd = pwdata & lane;
    wire [31:0] keep = ~lane;
    wire [31:0] fmt_word = {1'b0, fmt[3], 1'b0, fmt[2], 1'b0, fmt[1], 1'b0, fmt[0]};

    wire [31:0] stat_word = {22'h0, align_req, out_disable_pin, dclk, active};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_xpt) begin
            rd_mux = {24'h000000, xpt};
        end else if (hit_dis) begin
            rd_mux = {20'h00000, dis_cfg};
        end else if (hit_fmt) begin
            rd_mux = fmt_word;
        end else if (hit_stat) begin
            rd_mux = stat_word;
        end else if (hit_half) begin
            rd_mux = {16'h0000, half[idx]};
        end else if (hit_skew) begin
            rd_mux = {24'h000000, skew[idx]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (pce) begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // A hard reset restores the stored defaults, then realigns one cycle later
    // so that the dividers pick up the restored delays.
    wire [31:0] ctrl_in = wd & {32{wr_go & hit_ctrl}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hard_req <= 1'b0;
            align_req <= 1'b1;
        end else if (pce) begin
            hard_req <= ctrl_in[CTRL_HARD_BIT];
            align_req <= hard_req | ctrl_in[CTRL_SYNC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xpt <= XPT_DEFAULT;
            dis_cfg <= DIS_RST;
            fmt <= {NUM_DRV{FMT_RST}};
        end else if (pce) begin
            if (hard_req) begin
                xpt <= XPT_DEFAULT;
                dis_cfg <= DIS_RST;
                fmt <= {NUM_DRV{FMT_RST}};
            end else if (wr_go) begin
                if (hit_xpt) begin
                    xpt <= (xpt & keep[7:0]) | wd[7:0];
                end
                if (hit_dis) begin
                    dis_cfg <= (dis_cfg & keep[11:0]) | wd[11:0];
                end
                if (hit_fmt) begin
                    for (int i = 0; i < NUM_DRV; i++) begin
                        fmt[i] <= (fmt[i] & keep[i*FMT_W +: 7]) | wd[i*FMT_W +: 7];
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half <= {NUM_DIV{HALF_RST}};
            skew <= {NUM_DIV{SKEW_DEFAULT}};
        end else if (pce) begin
            if (hard_req) begin
                half <= {NUM_DIV{HALF_RST}};
                skew <= {NUM_DIV{SKEW_DEFAULT}};
            end else if (wr_go & hit_half) begin
                half[idx] <= (half[idx] & keep[HALF_W-1:0]) | wd[HALF_W-1:0];
            end else if (wr_go & hit_skew) begin
                skew[idx] <= (skew[idx] & keep[SKEW_W-1:0]) | wd[SKEW_W-1:0];
            end
        end
    end

    // Dividers: after a realign each waits its biased delay, then runs.
    for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
        ocdc_align_e state;
        logic [HALF_W-1:0] cnt;
        wire [HALF_W-1:0] reload = (half[k] == '0) ? '0 : half[k] - 1'b1;
        wire [HALF_W-1:0] wait_cnt = {8'h00, skew[k] + SKEW_BIAS};
        wire at_zero = cnt == '0;
        assign drise[k] = at_zero & ~align_req & ((state == OCDC_ALIGN_WAIT) | ~dclk[k]);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state <= OCDC_ALIGN_WAIT;
                cnt <= '0;
                dclk[k] <= 1'b0;
            end else if (pce) begin
                if (align_req) begin
                    state <= OCDC_ALIGN_WAIT;
                    cnt <= wait_cnt;
                    dclk[k] <= 1'b0;
                end else if (!at_zero) begin
                    cnt <= cnt - 1'b1;
                end else begin
                    case (state)
                        OCDC_ALIGN_WAIT: begin
                            state <= OCDC_ALIGN_RUN;
                            dclk[k] <= 1'b1;
                        end
                        OCDC_ALIGN_RUN: begin
                            dclk[k] <= ~dclk[k];
                        end
                        default: begin
                            state <= OCDC_ALIGN_WAIT;
                        end
                    endcase
                    cnt <= reload;
                end
            end
        end
    end

    // Drivers. Enabling always waits for a period boundary so that an enable
    // cannot cut a half pulse either.
    for (genvar i = 0; i < NUM_DRV; i++) begin : g_drv
        wire [SEL_W-1:0] src = xpt[i*SEL_W +: SEL_W];
        wire sclk = dclk[src];
        wire srise = drise[src];
        wire pd = dis_cfg[PD_LSB + i];
        wire want = ~out_disable_pin & ~dis_cfg[DIS_LSB + i] & ~pd;
        wire sync_dis = dis_cfg[SYNCDIS_LSB + i];
        wire drop = sync_dis ? srise : 1'b1;
        wire next_active = want ? (active[i] | srise) : (active[i] & ~drop);
        wire p_lvl = sclk ^ fmt[i].inv_p;
        wire n_lvl = fmt[i].single_ended ? sclk ^ fmt[i].inv_n : ~p_lvl;
        wire dis_hi = fmt[i].dis_state == OCDC_DIS_HIGH;
        wire dis_drv = (fmt[i].dis_state == OCDC_DIS_LOW) | dis_hi;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                active[i] <= 1'b0;
                pin_p[i] <= 2'b01;
                pin_n[i] <= 2'b01;
                drive_sel[i] <= 2'b00;
                power_down[i] <= 1'b0;
            end else if (pce) begin
                active[i] <= next_active;
                drive_sel[i] <= fmt[i].drive;
                power_down[i] <= pd;
                if (active[i]) begin
                    pin_p[i] <= {p_lvl, 1'b1};
                    pin_n[i] <= {n_lvl, 1'b1};
                end else begin
                    pin_p[i] <= {dis_hi, dis_drv};
                    pin_n[i] <= {dis_hi, dis_drv};
                end
            end
        end
    end

endmodule

// ---- design/ocdc_pkg.sv ----
package ocdc_pkg;

    localparam int NUM_DIV = 4;
    localparam int NUM_DRV = 4;
    localparam int SEL_W = 2;
    localparam int HALF_W = 16;
    localparam int SKEW_W = 8;

    // Printed figures for the path delay; one step maps to one pclk cycle here.
    localparam int SKEW_STEP_FS = 280;
    localparam int SKEW_RANGE_PS = 9140;
    localparam logic [SKEW_W-1:0] SKEW_BIAS = 8'h80;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_XPT = 8'h04;
    localparam logic [7:0] ADDR_DIS = 8'h08;
    localparam logic [7:0] ADDR_FMT = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [3:0] PAGE_HALF = 4'h2;
    localparam logic [3:0] PAGE_SKEW = 4'h3;

    localparam int CTRL_HARD_BIT = 0;
    localparam int CTRL_SYNC_BIT = 1;
    localparam int DIS_LSB = 0;
    localparam int SYNCDIS_LSB = 4;
    localparam int PD_LSB = 8;
    localparam int FMT_W = 8;
    localparam int STAT_CLK_LSB = 4;
    localparam int STAT_PIN_BIT = 8;
    localparam int STAT_ALIGN_BIT = 9;

    localparam logic [7:0] XPT_RST = 8'hE4;
    localparam logic [11:0] DIS_RST = 12'h000;
    localparam logic [HALF_W-1:0] HALF_RST = 16'h0004;
    localparam logic [SKEW_W-1:0] SKEW_RST = 8'h00;

    typedef enum logic [1:0] {
        OCDC_DIS_LOW = 2'b00,
        OCDC_DIS_HIGH = 2'b01,
        OCDC_DIS_HIZ = 2'b10
    } ocdc_dis_e;

    typedef enum logic {
        OCDC_ALIGN_WAIT = 1'b0,
        OCDC_ALIGN_RUN = 1'b1
    } ocdc_align_e;

    typedef struct packed {
        logic [1:0] drive;
        logic inv_n;
        logic inv_p;
        logic single_ended;
        logic [1:0] dis_state;
    } ocdc_fmt_s;

    localparam ocdc_fmt_s FMT_RST = 7'h00;

    typedef struct packed {
        logic o;
        logic oe;
    } ocdc_pin_s;

endpackage

// ---- tb/ocdc_checker.sv ----
`timescale 1ns/1ps
module ocdc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic out_disable_pin,
    input ocdc_pkg::ocdc_pin_s [3:0] pin_p,
    input ocdc_pkg::ocdc_pin_s [3:0] pin_n,
    input wire logic [3:0][1:0] drive_sel,
    input wire logic [3:0] power_down
);
    import ocdc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready && pwrite;
    wire wr_fmt = acc && paddr == ADDR_FMT;
    wire wr_dis = acc && paddr == ADDR_DIS;
    wire wr_ctl = acc && paddr == ADDR_CTRL;
    // Counters stand in for long repetitions, which the tools would unroll.
    logic [7:0] up_cnt;
    logic [4:0] off_cnt;
    logic [4:0] pd_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 8'h00;
            off_cnt <= 5'h00;
            pd_cnt <= 5'h00;
        end else begin
            up_cnt <= up_cnt + {7'h00, up_cnt != 8'hFF};
            off_cnt <= out_disable_pin ? off_cnt + {4'h0, off_cnt != 5'h1F} : 5'h00;
            pd_cnt <= power_down[0] ? pd_cnt + {4'h0, pd_cnt != 5'h1F} : 5'h00;
        end
    end
    a_reset_quiet: assert property (disable iff (1'b0)
        !presetn |-> !pready && power_down == 4'h0 && drive_sel == 8'h00)
        else $error("outputs not at defaults in reset");
    a_boot_quiet: assert property (up_cnt > 8'h04 && up_cnt < 8'h78
        |-> $stable(pin_p) && $stable(pin_n)) else $error("pins moved before start");
    a_pin_still: assert property (off_cnt > 5'h0E
        |-> $stable(pin_p) && $stable(pin_n)) else $error("pins moved while disabled");
    a_park_still: assert property (pd_cnt > 5'h0E
        |-> $stable(pin_p[0]) && $stable(pin_n[0])) else $error("parked pin moved");
    a_drive_copy: assert property (wr_fmt
        |-> ##2 drive_sel[0] == $past(pwdata[6:5], 2)) else $error("drive select wrong");
    a_pd_copy: assert property ($past(wr_dis, 2)
        |-> power_down == $past(pwdata[11:8], 2)) else $error("power down wrong");
    a_hard_load: assert property (wr_ctl && pwdata[0]
        |-> ##3 power_down == 4'h0 && drive_sel == 8'h00) else $error("hard reset missed");
    a_sync_quiet: assert property (wr_ctl && pwdata[1]
        |-> ##5 ($stable(pin_p) && $stable(pin_n))[*8]) else $error("no realign");
endmodule
bind ocdc_top ocdc_checker ocdc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .out_disable_pin, .pin_p, .pin_n, .drive_sel, .power_down);

// ---- tb/ocdc_sink.sv ----
`timescale 1ns/1ps
module ocdc_sink (
    input ocdc_pkg::ocdc_pin_s pin,
    output int edges
);
    import ocdc_pkg::*;
    // A receiver counts only driven edges; a floating input gives no clock.
    initial edges = 0;
    always @(posedge pin.o) begin
        if (pin.oe) begin
            edges = edges + 1;
        end
    end
endmodule

// ---- tb/output_clock_distribution_ctrl_bench.sv ----
`timescale 1ns/1ps
module output_clock_distribution_ctrl_bench;
    import ocdc_pkg::*;
    logic pclk = 1'b0;
    logic presetn;
    logic pce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic out_disable_pin = 1'b0;
    ocdc_pin_s [3:0] pin_p;
    ocdc_pin_s [3:0] pin_n;
    logic [3:0][1:0] drive_sel;
    logic [3:0] power_down;
    int edges [4];
    int n_fail = 0;
    int num_checks = 0;
    logic [31:0] q;
    logic e;
    int a;
    int b;
    ocdc_top ocdc_top_i (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .out_disable_pin, .pin_p, .pin_n, .drive_sel,
        .power_down);
    for (genvar g = 0; g < 4; g++) begin : sink
        ocdc_sink ocdc_sink_i (.pin(pin_p[g]), .edges(edges[g]));
    end
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic xe);
        bus(1'b0, ad, 32'h0);
        chk(q, x);
        chk(32'(e), 32'(xe));
    endtask
    // Edge counts over a window; one edge of slack covers the unknown start phase.
    task automatic rate(input int k, input int x);
        int s;
        s = edges[k];
        repeat (400) @(posedge pclk);
        s = edges[k] - s;
        chk(32'(s >= x - 1 && s <= x + 1), 32'h1);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        test_done();
    end
    initial begin
        // Reset is entered by an edge at time zero, so every flop starts known.
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'({pin_n, pin_p}), 32'h5555);
        repeat (140) @(posedge pclk);
        rd(ADDR_XPT, 32'hE4, 1'b0);
        rd(8'h30, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            rate(k, 50);
        end
        bus(1'b1, 8'h34, 32'h8);
        bus(1'b1, ADDR_CTRL, 32'h2);
        repeat (8) @(posedge pclk);
        a = 0;
        b = 0;
        for (int i = 1; i < 300; i++) begin
            @(posedge pclk);
            if (a == 0 && pin_p[0].o === 1'b1) a = i;
            if (b == 0 && pin_p[1].o === 1'b1) b = i;
        end
        chk(32'(b - a), 32'h8);
        rd(8'h34, 32'h8, 1'b0);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'(8'h20 + 4 * k), 32'(k + 2));
        end
        bus(1'b1, ADDR_CTRL, 32'h2);
        bus(1'b1, ADDR_XPT, 32'hE7);
        repeat (150) @(posedge pclk);
        rate(0, 40);
        rate(1, 66);
        bus(1'b1, ADDR_FMT, 32'h0400);
        repeat (6) @(posedge pclk);
        chk(32'(pin_n[1].o), 32'(pin_p[1].o));
        for (int d = 0; d < 3; d++) begin
            bus(1'b1, ADDR_FMT, 32'h00021500 | 32'(d << 5));
            repeat (2) @(posedge pclk);
            chk(32'(drive_sel[0]), 32'(d));
            chk(32'(pin_n[1].o), 32'(!pin_p[1].o));
        end
        out_disable_pin <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(32'({pin_p[3], pin_p[1], pin_p[0], pin_p[2].oe}), 32'h3A);
        out_disable_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        rate(3, 40);
        bus(1'b1, 8'h34, 32'h5);
        bus(1'b1, ADDR_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        rd(ADDR_XPT, 32'hE4, 1'b0);
        rd(8'h34, 32'h0, 1'b0);
        bus(1'b1, 8'h20, 32'h14);
        bus(1'b1, 8'h24, 32'h14);
        bus(1'b1, ADDR_CTRL, 32'h2);
        repeat (150) @(posedge pclk);
        // Start right at a fresh high half, so both pins are surely high when disabled.
        @(posedge pin_p[0].o);
        @(posedge pclk);
        bus(1'b1, ADDR_DIS, 32'h13);
        repeat (2) @(posedge pclk);
        chk(32'({pin_p[0].o, pin_p[1].o}), 32'h2);
        repeat (40) @(posedge pclk);
        chk(32'(pin_p[0].o), 32'h0);
        bus(1'b1, ADDR_DIS, 32'h100);
        repeat (2) @(posedge pclk);
        chk(32'(power_down), 32'h1);
        a = edges[0];
        repeat (60) @(posedge pclk);
        chk(32'(edges[0] - a), 32'h0);
        test_done();
    end
endmodule
